// ---- lcpg_cfg.svh ----
`ifndef LCPG_CFG_SVH
`define LCPG_CFG_SVH
// Number of independent drivers
`define LCPG_NUM_DRV        2
// Reset value of the gate enable (pulses blocked)
`define LCPG_GATE_RST       1'b0
// Reset value of a synchronised control input (inactive high)
`define LCPG_CTRL_RST       1'b1
// Mode-rise guard window after source clock fall, in ns
`define LCPG_MODE_GUARD_NS  20
// Clock period in ns
`define LCPG_CLK_NS         10
// Guard window in cycles, rounded down, at least one
`define LCPG_MODE_GUARD_CYC \
  (((`LCPG_MODE_GUARD_NS / `LCPG_CLK_NS) < 1) ? 1 : (`LCPG_MODE_GUARD_NS / `LCPG_CLK_NS))
`endif

// ---- lcpg_driver.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lcpg_cfg.svh"
module lcpg_driver (
  input  wire logic                i_clock,   // System clock
  input  wire logic                i_reset_n, // Sync reset, active low
  input  wire lcpg_pkg::lcpg_ctrl_s i_ctrl,   // Raw pin levels
  output var  lcpg_pkg::lcpg_out_s o_out,     // Gated clock pair
  output logic                     o_gate_en  // Gate enable state
);
  import lcpg_pkg::*;

  lcpg_ctrl_s meta_ff;
  lcpg_ctrl_s sync_ff;
  lcpg_ctrl_s prev_ff;
  lcpg_gate_e state_ff;
  logic       out_ff;

  // Two-flop synchroniser; pins are asynchronous and may bounce
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      meta_ff <= '{1'b0, `LCPG_CTRL_RST, `LCPG_CTRL_RST, `LCPG_CTRL_RST, 1'b0};
      sync_ff <= '{1'b0, `LCPG_CTRL_RST, `LCPG_CTRL_RST, `LCPG_CTRL_RST, 1'b0};
    end else begin
      meta_ff <= i_ctrl;
      sync_ff <= meta_ff;
    end
  end

  // Previous sample for edge detection
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      prev_ff <= '{1'b0, `LCPG_CTRL_RST, `LCPG_CTRL_RST, `LCPG_CTRL_RST, 1'b0};
    end else begin
      prev_ff <= sync_ff;
    end
  end

  logic set_lvl;
  logic set_fall;
  logic stop_fall;
  logic clk_rise;
  assign set_lvl   = !sync_ff.set_in_a_n || !sync_ff.set_in_b_n;
  assign set_fall  = (prev_ff.set_in_a_n && !sync_ff.set_in_a_n)
                  || (prev_ff.set_in_b_n && !sync_ff.set_in_b_n);
  assign stop_fall = prev_ff.stop_n && !sync_ff.stop_n;
  assign clk_rise  = !prev_ff.src_clk && sync_ff.src_clk;

  logic pend_start_ff;
  logic pend_stop_ff;
  logic start_req;
  logic stop_req;
  // Start needs stop high now; a later steady stop low still inhibits
  assign start_req = (set_fall || pend_start_ff) && sync_ff.stop_n;
  assign stop_req  = stop_fall || pend_stop_ff;

  // Falls seen while the source clock is high wait for the low phase,
  // so a one-cycle tap is kept unless set and stop fall in one cycle; the latest fall wins
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      pend_start_ff <= 1'b0;
      pend_stop_ff  <= 1'b0;
    end else if (!sync_ff.src_clk) begin
      pend_start_ff <= 1'b0;
      pend_stop_ff  <= 1'b0;
    end else if (set_fall && sync_ff.stop_n) begin
      pend_start_ff <= 1'b1;
      pend_stop_ff  <= 1'b0;
    end else if (stop_fall && !set_lvl) begin
      pend_start_ff <= 1'b0;
      pend_stop_ff  <= 1'b1;
    end
  end

  logic gate_on;
  assign gate_on = (state_ff == LCPG_TRAIN) || (state_ff == LCPG_SINGLE);

  // Latched gate state; changes only while source clock is low, except SINGLE to DONE on a rising source edge
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state_ff <= LCPG_IDLE;
    end else if (!sync_ff.src_clk && !clk_rise) begin
      // Set fall with stop high starts; set held low passes
      if (start_req) begin
        state_ff <= sync_ff.mode ? LCPG_SINGLE : LCPG_TRAIN;
      end else if (set_lvl) begin
        // A held set level leaves a finished single pulse in DONE with mode high, but moves it to TRAIN with mode low
        if (!sync_ff.mode) begin
          state_ff <= LCPG_TRAIN;
        end else if (state_ff == LCPG_TRAIN || state_ff == LCPG_IDLE) begin
          state_ff <= LCPG_SINGLE;
        end
      end else if (!sync_ff.stop_n || stop_req) begin
        state_ff <= LCPG_IDLE;
      end else if (state_ff == LCPG_TRAIN && sync_ff.mode) begin
        state_ff <= LCPG_SINGLE;
      end
      // Set and stop high, not TRAIN with mode high: state held
    end else if (clk_rise && state_ff == LCPG_SINGLE) begin
      state_ff <= LCPG_DONE;
    end
  end

  // Output pulse: starts only on a rising source edge, runs full width
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      out_ff <= 1'b0;
    end else if (!sync_ff.src_clk) begin
      out_ff <= 1'b0;
    end else if (clk_rise) begin
      out_ff <= gate_on;
    end
  end

  assign o_out.clk_true = out_ff;
  assign o_out.clk_inv  = !out_ff;
  assign o_gate_en      = gate_on;

  // Pulse never clipped once started
  a_pulse_full: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (out_ff && sync_ff.src_clk) |=> (out_ff || !sync_ff.src_clk))
    else $error("pulse clipped");
  a_outs_comp: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    o_out.clk_true != o_out.clk_inv)
    else $error("outputs not complementary");
  a_gate_lowclk: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (sync_ff.src_clk && !clk_rise) |=> $stable(state_ff))
    else $error("gate changed while clock high");
  a_set_passes: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (set_lvl && !sync_ff.mode && !sync_ff.src_clk) |=> state_ff == LCPG_TRAIN)
    else $error("set low did not pass");
  a_stop_inhib: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (!set_lvl && !sync_ff.stop_n && !sync_ff.src_clk) |=> state_ff == LCPG_IDLE)
    else $error("stop did not inhibit");
  a_hold_state: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (!set_lvl && sync_ff.stop_n && !start_req && !stop_req && !sync_ff.mode
      && state_ff != LCPG_SINGLE) |=> $stable(state_ff))
    else $error("state lost with controls high");
  a_single_once: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (clk_rise && state_ff == LCPG_SINGLE) |=> state_ff == LCPG_DONE)
    else $error("single pulse not ended");
  a_train_pass: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (clk_rise && state_ff == LCPG_TRAIN) |=> out_ff)
    else $error("train pulse dropped");
  a_blocked_out: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    (clk_rise && !gate_on) |=> !out_ff)
    else $error("pulse passed while blocked");

  c_train: cover property (@(posedge i_clock) disable iff (!i_reset_n)
    state_ff == LCPG_TRAIN ##1 out_ff);
  c_single: cover property (@(posedge i_clock) disable iff (!i_reset_n)
    state_ff == LCPG_SINGLE ##1 state_ff == LCPG_DONE);
  c_stop: cover property (@(posedge i_clock) disable iff (!i_reset_n)
    state_ff == LCPG_TRAIN ##1 state_ff == LCPG_IDLE);
endmodule // lcpg_driver
`default_nettype wire

// ---- lcpg_pkg.sv ----
`default_nettype none
package lcpg_pkg;
  // Control pins of one driver
  typedef struct packed {
    logic src_clk;   // Free-running source clock
    logic set_in_a_n; // Set latch input a
    logic set_in_b_n; // Set latch input b
    logic stop_n;    // Stop / clear latch input
    logic mode;      // High = single pulse
  } lcpg_ctrl_s;
  // Complementary outputs of one driver
  typedef struct packed {
    logic clk_true;
    logic clk_inv;
  } lcpg_out_s;
  // Gate state of one driver
  typedef enum logic [1:0] {
    LCPG_IDLE,
    LCPG_TRAIN,
    LCPG_SINGLE,
    LCPG_DONE
  } lcpg_gate_e;
endpackage
`default_nettype wire

// ---- lcpg_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcpg_src_model (
  input  wire logic                      i_clock,   // System clock
  input  wire logic                      i_reset_n, // Sync reset, active low
  input  wire lcpg_pkg::lcpg_out_s [1:0] i_out,     // Gated pairs
  output logic                     [1:0] o_src,     // Source clocks
  output logic                [1:0][7:0] o_cnt,     // Pulses seen
  output logic                           o_split    // Pair not opposite
);
  import lcpg_pkg::*;
  logic [2:0] phase_ff;
  logic [1:0] prev_ff;
  // Source clocks, 8 cycles, drivers in antiphase to expose crosstalk
  always_ff @(posedge i_clock) begin
    phase_ff <= i_reset_n ? phase_ff + 3'h1 : 3'h0;
  end
  assign o_src = {~phase_ff[2], phase_ff[2]};
  // Count rising edges of each gated clock
  always_ff @(posedge i_clock) begin
    prev_ff <= {i_out[1].clk_true, i_out[0].clk_true};
    for (int g = 0; g < 2; g++) begin
      if (!i_reset_n) o_cnt[g] <= 8'h00;
      else if (i_out[g].clk_true && !prev_ff[g]) o_cnt[g] <= o_cnt[g] + 8'h01;
    end
  end
  // Sticky: an unknown on one output of a pair also counts as not opposite
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) o_split <= 1'b0;
    else if (i_out[0].clk_inv !== ~i_out[0].clk_true ||
             i_out[1].clk_inv !== ~i_out[1].clk_true) o_split <= 1'b1;
  end
endmodule // lcpg_src_model
`default_nettype wire

// ---- lcpg_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lcpg_cfg.svh"
// How it works
// - Set and stop inputs are latched; bounce and hold time do not matter.
// - Set low passes, stop low inhibits, set fall starts, stop fall stops.
// - With set and stop high and mode low, the last established gate state is kept, except that a single ends after its pulse.
// - Once started and not stopped, every pulse passes while mode is low.
// - With mode high only one pulse passes per start, then pulses block.
// - In train mode the control sampled before a pulse decides the last.
// - Mode rise ends a train after passing the following pulse.
// - A pulse once begun is passed at full width.
// - Each driver gives true and inverted complementary clock outputs.
// - Unconnected control inputs need pad pull-ups to read high and be inactive.
// - Two identical independent drivers.
module lcpg_top (
  input  wire logic                                 i_clock,   // System clock 100 MHz
  input  wire logic                                 i_reset_n, // Sync reset, active low
  input  wire lcpg_pkg::lcpg_ctrl_s [`LCPG_NUM_DRV-1:0] i_ctrl, // Pins per driver
  output var  lcpg_pkg::lcpg_out_s  [`LCPG_NUM_DRV-1:0] o_out,  // Clock pairs
  output logic                      [`LCPG_NUM_DRV-1:0] o_gate_en // Gate states
);
  import lcpg_pkg::*;

  // Identical independent drivers; pull-ups are the pad's job, so
  // the testbench drives 1 for an open control pin
  for (genvar g = 0; g < `LCPG_NUM_DRV; g++) begin : g_drv
    lcpg_driver u_drv (
      .i_clock   (i_clock),
      .i_reset_n (i_reset_n),
      .i_ctrl    (i_ctrl[g]),
      .o_out     (o_out[g]),
      .o_gate_en (o_gate_en[g])
    );
  end
endmodule // lcpg_top
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lcpg_pkg::*;
  logic             i_clock = 1'b0;
  logic             i_reset_n = 1'b0;
  logic [1:0]       sa_n = 2'h3, sb_n = 2'h3, st_n = 2'h3, md = 2'h0;
  logic [1:0]       src, gate;
  logic [1:0][7:0]  cnt;
  logic             split;
  lcpg_ctrl_s [1:0] ctrl;
  lcpg_out_s  [1:0] outs;
  int               n_fail = 0, compares = 0;
  always #5 i_clock = ~i_clock;
  assign ctrl[0] = '{src[0], sa_n[0], sb_n[0], st_n[0], md[0]};
  assign ctrl[1] = '{src[1], sa_n[1], sb_n[1], st_n[1], md[1]};
  lcpg_top lcpg_top_inst (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_ctrl(ctrl),
    .o_out(outs), .o_gate_en(gate));
  lcpg_src_model lcpg_src_model_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_out(outs), .o_src(src), .o_cnt(cnt), .o_split(split));
  task automatic give_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("BAD %s exp %0d got %0d", what, exp, got);
      n_fail++;
    end
  endtask
  // Count gated pulses over n cycles; a train gives one per 8 cycles
  task automatic pulses(input int g, input int n, input logic [7:0] exp);
    logic [7:0] c0;
    c0 = cnt[g];
    repeat (n) @(negedge i_clock);
    chk(g ? "pulses1" : "pulses0", exp, cnt[g] - c0);
  endtask
  // One-cycle low pulse: the latch must hold it
  task automatic tap(ref logic [1:0] v, input int g);
    v[g] = 1'b0;
    @(negedge i_clock);
    v[g] = 1'b1;
    repeat (16) @(negedge i_clock);
  endtask
  task automatic t_train;
    logic [7:0] c1;
    c1 = cnt[1];
    tap(sa_n, 0);
    pulses(0, 32, 4);
    chk("gate0", 8'h01, {7'h00, gate[0]});
    chk("idle1", c1, cnt[1]);
  endtask
  task automatic t_stop;
    tap(st_n, 0);
    pulses(0, 32, 0);
  endtask
  // Held set level outranks a stop pulse
  task automatic t_level;
    sb_n[0] = 1'b0;
    tap(st_n, 0);
    pulses(0, 32, 4);
    sb_n[0] = 1'b1;
    tap(st_n, 0);
  endtask
  task automatic t_single;
    md[1] = 1'b1;
    sb_n[1] = 1'b0;
    @(negedge i_clock);
    sb_n[1] = 1'b1;
    pulses(1, 48, 1);
    chk("gate1", 8'h00, {7'h00, gate[1]});
    md[1] = 1'b0;
  endtask
  // Raise mode mid-pulse, clear of the guard after the fall
  task automatic t_mode_end;
    int k;
    k = 0;
    tap(sa_n, 0);
    while (src[0] !== 1'b0 && k < 20) begin @(negedge i_clock); k++; end
    while (src[0] !== 1'b1 && k < 20) begin @(negedge i_clock); k++; end
    if (k >= 20) begin
      $display("BAD wait_src exp 20 got %0d", k);
      n_fail++;
      give_verdict;
    end
    repeat (3) @(negedge i_clock);
    md[0] = 1'b1;
    // Let the pulse already in flight be counted before the window opens
    repeat (2) @(negedge i_clock);
    pulses(0, 48, 1);
  endtask
  // Main sequence
  initial begin
    repeat (3) @(negedge i_clock);
    i_reset_n = 1'b1;
    repeat (4) @(negedge i_clock);
    pulses(0, 32, 0);
    pulses(1, 32, 0);
    t_train;
    t_stop;
    t_level;
    t_single;
    t_mode_end;
    chk("split", 8'h00, {7'h00, split});
    give_verdict;
  end
endmodule // tb
`default_nettype wire
